// file: hw/pbcc_regs.vh
// Register map, field positions, reset values and timing counts
`ifndef PBCC_REGS_VH
`define PBCC_REGS_VH

// ===========================================================
// Register word offsets (byte addresses)
`define PBCC_ADDR_W 8
`define PBCC_OFS_CTRL 8'h00
`define PBCC_OFS_BWC 8'h04

// ===========================================================
// Control register fields
`define PBCC_IE_BIT 7
`define PBCC_FLAG_BIT 6
`define PBCC_LON_BIT 5
`define PBCC_BCS_BIT 4

// ===========================================================
// Bandwidth control register fields
`define PBCC_AUTO_BIT 7
`define PBCC_LOCK_BIT 6
`define PBCC_ACQ_BIT 5

// ===========================================================
// Reset values
`define PBCC_CTRL_RST 8'h20
`define PBCC_BWC_RST 8'h00

// ===========================================================
// Switchover: edges of each source to wait out
`define PBCC_SWITCH_EDGES 2'h3

// ===========================================================
// Bus responses
`define PBCC_RESP_OKAY 2'h0
`define PBCC_RESP_SLVERR 2'h2

`endif

// file: hw/pbcc_top.v
// Base clock selector and PLL control registers behind AXI4-Lite
//
// How it works
// - Base output is selected source halved, 50 percent.
// - Select one takes VCO clock, zero oscillator.
// - Hold output static three edges per source.
// - Select cannot be set while loop off.
// - Loop enable stays set while VCO selected.
// - Reset sets loop enable, clears select.
// - Interrupt enable locked, reads zero in manual.
// - Lock change sets flag; flag and enable interrupt in automatic.
// - Flag reads zero in manual; reset clears.
// - Reading control register clears the flag.
// - Interrupt output from lock detector path.
// - Bandwidth mode one automatic, zero manual.
// - Lock reads detector in automatic, else zero.
// - Acquisition bit status in auto, control manual.
// - Manual acquisition value kept through automatic.
// - Acquisition one tracking, zero acquisition; reset zero.
// - Reference clock is filtered, resynchronised oscillator copy.
// - Bus clock is source divided by four.
`timescale 1ns/1ns
`include "pbcc_regs.vh"
`default_nettype none

module pbcc_top (
  // Clock and reset
  input wire ref_clk,
  input wire rst,
  // AXI4-Lite write address
  input wire s_axi_awvalid,
  output wire s_axi_awready,
  input wire [`PBCC_ADDR_W-1:0] s_axi_awaddr,
  input wire [2:0] s_axi_awprot,
  // AXI4-Lite write data
  input wire s_axi_wvalid,
  output wire s_axi_wready,
  input wire [31:0] s_axi_wdata,
  input wire [3:0] s_axi_wstrb,
  // AXI4-Lite write response
  output wire s_axi_bvalid,
  input wire s_axi_bready,
  output wire [1:0] s_axi_bresp,
  // AXI4-Lite read address
  input wire s_axi_arvalid,
  output wire s_axi_arready,
  input wire [`PBCC_ADDR_W-1:0] s_axi_araddr,
  input wire [2:0] s_axi_arprot,
  // AXI4-Lite read data
  output wire s_axi_rvalid,
  input wire s_axi_rready,
  output wire [31:0] s_axi_rdata,
  output wire [1:0] s_axi_rresp,
  // Source clocks and detector pins
  input wire osc_clk,
  input wire vco_div_clk,
  input wire lock_det_in,
  input wire track_det_in,
  // Clock outputs
  output wire base_clk_out,
  output wire bus_clk_out,
  output wire pll_ref_clk,
  // Loop control and interrupt
  output wire loop_enable,
  output wire auto_bw_mode,
  output wire track_not_acquire,
  output wire switch_busy,
  output wire pll_irq
);

  // =========================================================
  // Helpers
  localparam ST_RUN = 2'b01;
  localparam ST_HOLD = 2'b10;

  // One-hot register select from a byte address
  function [1:0] reg_sel;
    input [`PBCC_ADDR_W-1:0] a;
    begin
      reg_sel[0] = (a[`PBCC_ADDR_W-1:2] == `PBCC_OFS_CTRL >> 2);
      reg_sel[1] = (a[`PBCC_ADDR_W-1:2] == `PBCC_OFS_BWC >> 2);
    end
  endfunction

  // Saturating edge counter for the switchover wait
  function [1:0] sat_inc;
    input [1:0] c;
    input ev;
    begin
      if (ev && c != `PBCC_SWITCH_EDGES) begin
        sat_inc = c + 2'h1;
      end else begin
        sat_inc = c;
      end
    end
  endfunction

  // =========================================================
  // Pin synchronisers
  // Bit 0 osc, 1 vco, 2 lock, 3 track. Sources must run well
  // below a quarter of ref_clk or edges are lost.
  reg [3:0] s1_r;
  reg [3:0] s2_r;
  reg [3:0] s3_r;
  reg [3:0] f_r;
  reg [3:0] prev_r;
  wire [3:0] agree;
  wire [3:0] f_nxt;
  wire osc_rise;
  wire vco_rise;
  wire lock_chg;

  assign agree = ~(s2_r ^ s3_r);
  assign f_nxt = (s2_r & agree) | (f_r & ~agree);

  always @(posedge ref_clk) begin
    if (rst) begin
      s1_r <= 4'h0;
      s2_r <= 4'h0;
      s3_r <= 4'h0;
      f_r <= 4'h0;
      prev_r <= 4'h0;
    end else begin
      s1_r <= {track_det_in, lock_det_in, vco_div_clk, osc_clk};
      s2_r <= s1_r;
      s3_r <= s2_r;
      f_r <= f_nxt;
      prev_r <= f_r;
    end
  end

  assign osc_rise = f_r[0] & ~prev_r[0];
  assign vco_rise = f_r[1] & ~prev_r[1];
  assign lock_chg = f_r[2] ^ prev_r[2];
  assign pll_ref_clk = f_r[0];

  // =========================================================
  // AXI4-Lite handshakes
  reg awready_r;
  reg wready_r;
  reg bvalid_r;
  reg [1:0] bresp_r;
  reg arready_r;
  reg rvalid_r;
  reg [31:0] rdata_r;
  reg [1:0] rresp_r;
  reg [`PBCC_ADDR_W-1:0] awaddr_q;
  reg [31:0] wdata_q;
  reg [3:0] wstrb_q;
  wire wr_go;
  wire rd_go;
  wire [1:0] wsel;
  wire [1:0] rsel;
  wire rd_ctrl;

  // Both halves held and no response pending
  assign wr_go = ~awready_r & ~wready_r & ~bvalid_r;
  assign rd_go = s_axi_arvalid & arready_r;
  assign wsel = reg_sel(awaddr_q);
  assign rsel = reg_sel(s_axi_araddr);
  assign rd_ctrl = rd_go & rsel[0];

  // =========================================================
  // Register state
  reg ie_r;
  reg flag_r;
  reg lon_r;
  reg bcs_r;
  reg auto_r;
  reg acq_r;
  reg irq_r;
  reg ie_nxt;
  reg flag_nxt;
  reg lon_nxt;
  reg bcs_nxt;
  reg auto_nxt;
  reg acq_nxt;
  reg [7:0] ctrl_rd;
  reg [7:0] bwc_rd;

  // Switch state, read by the write logic
  reg [1:0] st_r;
  reg act_sel_r;

  always @* begin
    ie_nxt = ie_r;
    lon_nxt = lon_r;
    bcs_nxt = bcs_r;
    auto_nxt = auto_r;
    acq_nxt = acq_r;
    if (wr_go && wstrb_q[0] && wsel[0]) begin
      if (auto_r) begin
        ie_nxt = wdata_q[`PBCC_IE_BIT];
      end
      // Also held while a switch away from VCO is pending
      lon_nxt = wdata_q[`PBCC_LON_BIT] | bcs_r | act_sel_r;
      if (!wdata_q[`PBCC_BCS_BIT]) begin
        bcs_nxt = 1'b0;
      end else if (lon_nxt) begin
        bcs_nxt = 1'b1;
      end
    end
    if (wr_go && wstrb_q[0] && wsel[1]) begin
      auto_nxt = wdata_q[`PBCC_AUTO_BIT];
      // Lock bit position is not stored on write
      if (!auto_r) begin
        acq_nxt = wdata_q[`PBCC_ACQ_BIT];
      end
    end
    // Set beats a read in the same cycle
    flag_nxt = lock_chg | (flag_r & ~rd_ctrl);
  end

  always @* begin
    ctrl_rd = 8'h00;
    ctrl_rd[`PBCC_IE_BIT] = ie_r & auto_r;
    ctrl_rd[`PBCC_FLAG_BIT] = flag_r & auto_r;
    ctrl_rd[`PBCC_LON_BIT] = lon_r;
    ctrl_rd[`PBCC_BCS_BIT] = bcs_r;
    bwc_rd = 8'h00;
    bwc_rd[`PBCC_AUTO_BIT] = auto_r;
    bwc_rd[`PBCC_LOCK_BIT] = f_r[2] & auto_r;
    // Status in automatic mode, stored value in manual
    bwc_rd[`PBCC_ACQ_BIT] = auto_r ? f_r[3] : acq_r;
  end

  always @(posedge ref_clk) begin
    if (rst) begin
      ie_r <= |(`PBCC_CTRL_RST & (8'h01 << `PBCC_IE_BIT));
      flag_r <= 1'b0;
      lon_r <= 1'b1;
      bcs_r <= 1'b0;
      auto_r <= 1'b0;
      acq_r <= 1'b0;
      irq_r <= 1'b0;
    end else begin
      ie_r <= ie_nxt;
      flag_r <= flag_nxt;
      lon_r <= lon_nxt;
      bcs_r <= bcs_nxt;
      auto_r <= auto_nxt;
      acq_r <= acq_nxt;
      irq_r <= flag_r & ie_r & auto_r;
    end
  end

  // =========================================================
  // Bus slave sequencing
  always @(posedge ref_clk) begin
    if (rst) begin
      awready_r <= 1'b1;
      wready_r <= 1'b1;
      bvalid_r <= 1'b0;
      bresp_r <= `PBCC_RESP_OKAY;
      arready_r <= 1'b1;
      rvalid_r <= 1'b0;
      rdata_r <= 32'h0;
      rresp_r <= `PBCC_RESP_OKAY;
      awaddr_q <= {`PBCC_ADDR_W{1'b0}};
      wdata_q <= 32'h0;
      wstrb_q <= 4'h0;
    end else begin
      if (s_axi_awvalid && awready_r) begin
        awaddr_q <= s_axi_awaddr;
        awready_r <= 1'b0;
      end
      if (s_axi_wvalid && wready_r) begin
        wdata_q <= s_axi_wdata;
        wstrb_q <= s_axi_wstrb;
        wready_r <= 1'b0;
      end
      if (wr_go) begin
        bvalid_r <= 1'b1;
        bresp_r <= (wsel != 2'h0) ? `PBCC_RESP_OKAY
                                  : `PBCC_RESP_SLVERR;
      end
      if (bvalid_r && s_axi_bready) begin
        bvalid_r <= 1'b0;
        awready_r <= 1'b1;
        wready_r <= 1'b1;
      end
      if (rd_go) begin
        arready_r <= 1'b0;
        rvalid_r <= 1'b1;
        if (rsel[0]) begin
          rdata_r <= {24'h0, ctrl_rd};
          rresp_r <= `PBCC_RESP_OKAY;
        end else if (rsel[1]) begin
          rdata_r <= {24'h0, bwc_rd};
          rresp_r <= `PBCC_RESP_OKAY;
        end else begin
          rdata_r <= 32'h0;
          rresp_r <= `PBCC_RESP_SLVERR;
        end
      end
      if (rvalid_r && s_axi_rready) begin
        rvalid_r <= 1'b0;
        arready_r <= 1'b1;
      end
    end
  end

  // =========================================================
  // Glitch-free base clock selector
  // The output toggles only on edges of the active source;
  // during a switch it freezes, so no pulse is shorter than
  // a full period of the faster source.
  reg base_r;
  reg bus_r;
  reg [1:0] cnt_osc_r;
  reg [1:0] cnt_vco_r;
  reg [1:0] st_nxt;
  reg act_sel_nxt;
  reg base_nxt;
  reg bus_nxt;
  reg [1:0] cnt_osc_nxt;
  reg [1:0] cnt_vco_nxt;
  wire src_rise;

  assign src_rise = act_sel_r ? vco_rise : osc_rise;

  always @* begin
    st_nxt = st_r;
    act_sel_nxt = act_sel_r;
    base_nxt = base_r;
    bus_nxt = bus_r;
    cnt_osc_nxt = cnt_osc_r;
    cnt_vco_nxt = cnt_vco_r;
    case (st_r)
      ST_RUN: begin
        if (bcs_r != act_sel_r) begin
          st_nxt = ST_HOLD;
          cnt_osc_nxt = 2'h0;
          cnt_vco_nxt = 2'h0;
        end else if (src_rise) begin
          base_nxt = ~base_r;
          if (!base_r) begin
            bus_nxt = ~bus_r;
          end
        end
      end
      ST_HOLD: begin
        // Wait out edges in each source domain
        cnt_osc_nxt = sat_inc(cnt_osc_r, osc_rise);
        cnt_vco_nxt = sat_inc(cnt_vco_r, vco_rise);
        if (cnt_osc_r == `PBCC_SWITCH_EDGES &&
            cnt_vco_r == `PBCC_SWITCH_EDGES) begin
          act_sel_nxt = bcs_r;
          st_nxt = ST_RUN;
        end
      end
      default: begin
        st_nxt = ST_RUN;
      end
    endcase
  end

  always @(posedge ref_clk) begin
    if (rst) begin
      st_r <= ST_RUN;
      act_sel_r <= 1'b0;
      base_r <= 1'b0;
      bus_r <= 1'b0;
      cnt_osc_r <= 2'h0;
      cnt_vco_r <= 2'h0;
    end else begin
      st_r <= st_nxt;
      act_sel_r <= act_sel_nxt;
      base_r <= base_nxt;
      bus_r <= bus_nxt;
      cnt_osc_r <= cnt_osc_nxt;
      cnt_vco_r <= cnt_vco_nxt;
    end
  end

  // =========================================================
  // Outputs, all straight from flip-flops
  assign s_axi_awready = awready_r;
  assign s_axi_wready = wready_r;
  assign s_axi_bvalid = bvalid_r;
  assign s_axi_bresp = bresp_r;
  assign s_axi_arready = arready_r;
  assign s_axi_rvalid = rvalid_r;
  assign s_axi_rdata = rdata_r;
  assign s_axi_rresp = rresp_r;
  assign base_clk_out = base_r;
  assign bus_clk_out = bus_r;
  assign loop_enable = lon_r;
  assign auto_bw_mode = auto_r;
  // Drives the stored manual value in both modes
  assign track_not_acquire = acq_r;
  assign switch_busy = st_r[1];
  assign pll_irq = irq_r;

endmodule // pbcc_top

`default_nettype wire

// file: verif/pbcc_src_model.sv
// Source clock and detector model for the base clock block
`timescale 1ns/1ns
`default_nettype none
// ==========================================
// Free-running sources, detector levels set by the bench
module pbcc_src_model (
  // Detector levels requested by the bench
  input wire logic lock_req,
  input wire logic track_req,
  // Pins toward the block
  output logic osc_clk,
  output logic vco_div_clk,
  output logic lock_det_in,
  output logic track_det_in
);
  // Both slower than ref_clk/8 so every level passes the input filter
  initial begin
    osc_clk = 1'b0;
    forever #500 osc_clk = ~osc_clk;
  end
  // Offset start keeps the two sources out of phase
  initial begin
    vco_div_clk = 1'b0;
    #130;
    forever #700 vco_div_clk = ~vco_div_clk;
  end
  assign lock_det_in = lock_req;
  assign track_det_in = track_req;
endmodule // pbcc_src_model
`default_nettype wire

// file: verif/pbcc_checker.sv
// Port-level assertions for the base clock block
`timescale 1ns/1ns
`default_nettype none
// ==========================================
// Checker
module pbcc_checker (
  // Clock and reset
  input wire logic ref_clk,
  input wire logic rst,
  // Bus handshakes
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_bvalid,
  // Block status
  input wire logic base_clk_out,
  input wire logic loop_enable,
  input wire logic auto_bw_mode,
  input wire logic track_not_acquire,
  input wire logic switch_busy,
  input wire logic pll_irq
);
  default clocking @(posedge ref_clk); endclocking
  default disable iff (rst);
  reset_state_a: assert property (
    $fell(rst) |-> loop_enable && !auto_bw_mode && !track_not_acquire
    && !pll_irq && !switch_busy) else $error("state after reset wrong");
  base_hold_a: assert property (
    switch_busy && $past(switch_busy) |-> $stable(base_clk_out))
    else $error("base clock moved during switchover");
  switch_bound_a: assert property (
    $rose(switch_busy) |-> ##[1:120] !switch_busy)
    else $error("switchover too long");
  switch_cause_a: assert property (
    $rose(switch_busy) |-> $past(s_axi_bvalid) || $past(s_axi_bvalid, 2))
    else $error("switchover without register write");
  irq_auto_a: assert property (
    pll_irq |-> $past(auto_bw_mode)) else $error("interrupt in manual mode");
  loop_clear_a: assert property (
    $fell(loop_enable) |-> $rose(s_axi_bvalid) && !$past(switch_busy))
    else $error("loop enable cleared wrongly");
  mode_write_a: assert property (
    $changed(auto_bw_mode) || $changed(track_not_acquire)
    |-> $rose(s_axi_bvalid)) else $error("mode bit changed without write");
  read_lat_a: assert property (
    s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("read answer late");
endmodule // pbcc_checker
bind pbcc_top pbcc_checker chk_u (.ref_clk(ref_clk), .rst(rst),
  .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
  .s_axi_rvalid(s_axi_rvalid), .s_axi_bvalid(s_axi_bvalid),
  .base_clk_out(base_clk_out), .loop_enable(loop_enable),
  .auto_bw_mode(auto_bw_mode), .track_not_acquire(track_not_acquire),
  .switch_busy(switch_busy), .pll_irq(pll_irq));
`default_nettype wire

// file: verif/tb.sv
// Self-checking bench for the base clock block
`timescale 1ns/1ns
`default_nettype none
`include "pbcc_regs.vh"
`define CHK(nm, e, g) begin cmp_count++; if ((g) !== (e)) begin \
  n_fail++; $display("[ERR] %s exp %h got %h", nm, e, g); end end
// ==========================================
// Bench
module tb;
  localparam logic [7:0] CT = `PBCC_OFS_CTRL;
  localparam logic [7:0] BW = `PBCC_OFS_BWC;
  localparam logic [1:0] OK = `PBCC_RESP_OKAY;
  localparam logic [1:0] ER = `PBCC_RESP_SLVERR;
  logic ref_clk = 1'b0;
  logic rst = 1'b1;
  logic awvalid, wvalid, bready, arvalid, rready, lock_req, track_req;
  logic [7:0] awaddr, araddr;
  logic [31:0] wdata;
  wire awready, wready, bvalid, arready, rvalid;
  wire [1:0] bresp, rresp;
  wire [31:0] rdata;
  wire osc_clk, vco_div_clk, lock_det_in, track_det_in;
  wire base_clk_out, bus_clk_out, pll_ref_clk, loop_enable;
  wire auto_bw_mode, track_not_acquire, switch_busy, pll_irq;
  int n_fail, cmp_count, cyc, n_osc, n_vco, n_base, n_bus, n_ref;
  always #50 ref_clk = ~ref_clk;
  pbcc_src_model src_u (.lock_req(lock_req), .track_req(track_req),
    .osc_clk(osc_clk), .vco_div_clk(vco_div_clk),
    .lock_det_in(lock_det_in), .track_det_in(track_det_in));
  pbcc_top dut_u (.ref_clk(ref_clk), .rst(rst),
    .s_axi_awvalid(awvalid), .s_axi_awready(awready),
    .s_axi_awaddr(awaddr), .s_axi_awprot(3'h0), .s_axi_wvalid(wvalid),
    .s_axi_wready(wready), .s_axi_wdata(wdata), .s_axi_wstrb(4'h1),
    .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_bresp(bresp),
    .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_araddr(araddr), .s_axi_arprot(3'h0), .s_axi_rvalid(rvalid),
    .s_axi_rready(rready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
    .osc_clk(osc_clk), .vco_div_clk(vco_div_clk),
    .lock_det_in(lock_det_in), .track_det_in(track_det_in),
    .base_clk_out(base_clk_out), .bus_clk_out(bus_clk_out),
    .pll_ref_clk(pll_ref_clk), .loop_enable(loop_enable),
    .auto_bw_mode(auto_bw_mode), .track_not_acquire(track_not_acquire),
    .switch_busy(switch_busy), .pll_irq(pll_irq));
  always @(posedge osc_clk) n_osc++;
  always @(posedge vco_div_clk) n_vco++;
  always @(posedge base_clk_out) n_base++;
  always @(posedge bus_clk_out) n_bus++;
  always @(posedge pll_ref_clk) n_ref++;
  task automatic finish_test();
    $display("comparisons %0d, mismatches %0d", cmp_count, n_fail);
    if (n_fail == 0 && cmp_count > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask
  // Hang guard, well above the fewer than two thousand cycles the tests need
  always @(posedge ref_clk) begin
    cyc++;
    if (cyc == 30000) begin
      n_fail++;
      finish_test();
    end
  end
  task automatic wr(input logic [7:0] a, d, input logic [1:0] er);
    // Idle edge, so bready is not raised in the step that lowered it
    @(posedge ref_clk);
    awaddr <= a;
    wdata <= {24'h0, d};
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do begin
      @(posedge ref_clk);
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
    end while (bvalid !== 1'b1);
    bready <= 1'b0;
    `CHK("bresp", er, bresp)
  endtask
  task automatic rd(input logic [7:0] a, e, input logic [1:0] er);
    @(posedge ref_clk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do begin
      @(posedge ref_clk);
      if (arready) arvalid <= 1'b0;
    end while (rvalid !== 1'b1);
    rready <= 1'b0;
    `CHK("rdata", {24'h0, e}, rdata)
    `CHK("rresp", er, rresp)
  endtask
  task automatic settle();
    repeat (2) @(posedge ref_clk);
    while (switch_busy !== 1'b0) @(posedge ref_clk);
  endtask
  // Edge counts over a window; one edge of slack for window phase
  task automatic ratio(input bit vco);
    int s0, b0, u0, r0, o0, ds, db;
    s0 = vco ? n_vco : n_osc;
    b0 = n_base;
    u0 = n_bus;
    r0 = n_ref;
    o0 = n_osc;
    repeat (600) @(posedge ref_clk);
    ds = (vco ? n_vco : n_osc) - s0;
    db = n_base - b0;
    `CHK("base_div", 1'b1, (2 * db - ds) inside {[-2:2]})
    `CHK("bus_div", 1'b1, (2 * (n_bus - u0) - db) inside {[-2:2]})
    `CHK("ref_copy", 1'b1, (n_ref - r0 - n_osc + o0) inside {[-1:1]})
  endtask
  task automatic t_reset();
    `CHK("loop_on", 1'b1, loop_enable)
    `CHK("auto", 1'b0, auto_bw_mode)
    `CHK("acq", 1'b0, track_not_acquire)
    rd(CT, `PBCC_CTRL_RST, OK);
    rd(BW, `PBCC_BWC_RST, OK);
    rd(8'h08, 8'h00, ER);
    wr(8'h0c, 8'hff, ER);
    $display("reset test done");
  endtask
  task automatic t_locks();
    wr(CT, 8'ha0, OK);
    rd(CT, 8'h20, OK);
    wr(CT, 8'h00, OK);
    `CHK("loop_off", 1'b0, loop_enable)
    wr(CT, 8'h10, OK);
    rd(CT, 8'h00, OK);
    `CHK("no_switch", 1'b0, switch_busy)
    wr(BW, 8'h00, OK);
    wr(CT, 8'h20, OK);
    $display("lock bits test done");
  endtask
  task automatic t_switch();
    ratio(1'b0);
    wr(CT, 8'h30, OK);
    settle();
    rd(CT, 8'h30, OK);
    ratio(1'b1);
    wr(CT, 8'h00, OK);
    rd(CT, 8'h20, OK);
    settle();
    wr(CT, 8'h00, OK);
    `CHK("loop_off", 1'b0, loop_enable)
    wr(CT, 8'h20, OK);
    $display("switch test done");
  endtask
  task automatic t_irq();
    wr(BW, 8'h20, OK);
    `CHK("acq_set", 1'b1, track_not_acquire)
    rd(BW, 8'h20, OK);
    track_req <= 1'b1;
    wr(BW, 8'ha0, OK);
    wr(CT, 8'ha0, OK);
    repeat (10) @(posedge ref_clk);
    rd(BW, 8'ha0, OK);
    rd(CT, 8'ha0, OK);
    lock_req <= 1'b1;
    repeat (10) @(posedge ref_clk);
    `CHK("irq", 1'b1, pll_irq)
    rd(BW, 8'he0, OK);
    rd(CT, 8'he0, OK);
    rd(CT, 8'ha0, OK);
    `CHK("irq_clr", 1'b0, pll_irq)
    `CHK("acq_kept", 1'b1, track_not_acquire)
    track_req <= 1'b0;
    wr(BW, 8'h00, OK);
    rd(BW, 8'h20, OK);
    lock_req <= 1'b0;
    repeat (10) @(posedge ref_clk);
    rd(CT, 8'h20, OK);
    `CHK("irq_man", 1'b0, pll_irq)
    $display("interrupt test done");
  endtask
  initial begin
    {awvalid, wvalid, bready, arvalid, rready} = 5'h0;
    {lock_req, track_req} = 2'h0;
    {awaddr, araddr} = 16'h0;
    wdata = 32'h0;
    repeat (6) @(posedge ref_clk);
    rst <= 1'b0;
    t_reset();
    t_locks();
    t_switch();
    t_irq();
    finish_test();
  end
endmodule // tb
`default_nettype wire
